//--- rtl/mbs_drive_regs.vh
// Constants for the drive-side Modbus-RTU slave: register map, codes, framing.
// Included by the slave core; holds definitions only.
`ifndef MBS_DRIVE_REGS_VH
`define MBS_DRIVE_REGS_VH

`define MBS_A_MODEL      4'h0
`define MBS_A_RATING     4'h1
`define MBS_A_SUPPLY     4'h2
`define MBS_A_FIRMWARE   4'h3
`define MBS_A_UNLOCK     4'h4
`define MBS_A_SETPOINT   4'h5
`define MBS_A_RUN        4'h6
`define MBS_A_RAMP_UP    4'h7
`define MBS_A_RAMP_DOWN  4'h8
`define MBS_A_CURRENT    4'h9
`define MBS_A_FREQ       4'ha
`define MBS_A_VOLT       4'hb
`define MBS_A_BUS_VOLT   4'hc
`define MBS_A_POWER      4'hd
`define MBS_A_STATE      4'he
`define MBS_A_FAULT      4'hf
`define MBS_A_LAST       16'h000f

`define MBS_FC_RD_HOLD   8'h03
`define MBS_FC_RD_INPUT  8'h04
`define MBS_FC_WR_ONE    8'h06
`define MBS_FC_WR_MANY   8'h10
`define MBS_FC_EXC       8'h80

`define MBS_EX_NONE      8'h00
`define MBS_EX_FUNC      8'h01
`define MBS_EX_ADDR      8'h02
`define MBS_EX_VALUE     8'h03
`define MBS_EX_BUSY      8'h06
`define MBS_EX_LOCK      8'h14

`define MBS_BROADCAST    8'h00
`define MBS_CRC_INIT     16'hffff
`define MBS_CRC_POLY     16'ha001

`define MBS_RC_FRST      3
`define MBS_RC_W         5
`define MBS_UNLOCK_RST   16'h0000
`define MBS_UNLOCK_MAX   16'h0001
`define MBS_RATING_SMALL 16'hffff

`define MBS_POS_SLV      6'h00
`define MBS_POS_FC       6'h01
`define MBS_POS_CNT      6'h02
`define MBS_POS_VAL      6'h04
`define MBS_POS_DATA     6'h07
`define MBS_LEN_MIN      6'h04
`define MBS_LEN_FIX      6'h08
`define MBS_LEN_HDR      9'h009
`define MBS_LEN_EXC      6'h03
`define MBS_LEN_RDH      6'h03
`define MBS_LEN_ECHO     6'h06
`define MBS_MAX_QTY      16'h0010

`define MBS_OVS          16
`define MBS_OVS_MID      4'h7
`define MBS_OVS_LAST     4'hf
`define MBS_TX_BITS_LAST 4'h9
`define MBS_T35_TICKS    10'h230
`define MBS_BAUD_RST     3'h3
`define MBS_BAUD_MAXC    3'h4
`define MBS_BAUD_1200    1200
`define MBS_BAUD_2400    2400
`define MBS_BAUD_4800    4800
`define MBS_BAUD_9600    9600
`define MBS_BAUD_19200   19200

`endif

//--- rtl/mbs_drive_slave.v
// Modbus-RTU slave core of a motor drive: UART, frame check, common register area.
// Assumes a half-duplex RS-485 transceiver on rx_i/tx_o/tx_en_o and drive-side
// status inputs that are synchronous to clk_i.
`timescale 1ns/1ps
`include "mbs_drive_regs.vh"

module mbs_drive_slave #(
	parameter CLK_HZ       = 125000000,
	parameter BUF_DEPTH    = 48,
	// Model code value is arbitrary
	parameter [15:0] MODEL = 16'h0042,
	parameter [15:0] FW_VER = 16'h0101,
	parameter [15:0] RAMP_UP_RST = 16'h0032,
	parameter [15:0] RAMP_DN_RST = 16'h0064
) (
	input  wire        clk_i,
	input  wire        rst_n_i,
	input  wire [7:0]  slave_addr_i,
	input  wire [2:0]  baud_sel_i,
	input  wire        baud_load_i,
	input  wire        rx_i,
	output reg         tx_o,
	output reg         tx_en_o,
	input  wire [1:0]  rating_sel_i,
	input  wire        supply_high_i,
	input  wire [15:0] start_freq_i,
	input  wire [15:0] max_freq_i,
	input  wire        motor_running_i,
	input  wire        busy_i,
	input  wire [15:0] current_i,
	input  wire [15:0] freq_i,
	input  wire [15:0] volt_i,
	input  wire [15:0] bus_volt_i,
	input  wire [15:0] power_i,
	input  wire [8:0]  drive_state_i,
	input  wire        brake_open_i,
	input  wire        brake_output_function_select_i,
	input  wire        remote_runstop_source_i,
	input  wire        remote_setpoint_source_i,
	input  wire [11:0] fault_cause_i,
	output reg  [15:0] param_unlock_o,
	output reg  [15:0] speed_setpoint_o,
	output reg  [4:0]  run_command_o,
	output reg  [15:0] ramp_up_time_o,
	output reg  [15:0] ramp_down_time_o,
	output reg         fault_reset_o,
	output reg  [2:0]  baud_code_o
);

	localparam integer D1200  = CLK_HZ / (`MBS_OVS * `MBS_BAUD_1200);
	localparam integer D2400  = CLK_HZ / (`MBS_OVS * `MBS_BAUD_2400);
	localparam integer D4800  = CLK_HZ / (`MBS_OVS * `MBS_BAUD_4800);
	localparam integer D9600  = CLK_HZ / (`MBS_OVS * `MBS_BAUD_9600);
	localparam integer D19200 = CLK_HZ / (`MBS_OVS * `MBS_BAUD_19200);
	localparam integer BUF_LAST_I = BUF_DEPTH - 1;
	localparam [5:0] BUF_LAST = BUF_LAST_I[5:0];

	localparam [1:0] RX_IDLE  = 2'b00;
	localparam [1:0] RX_START = 2'b01;
	localparam [1:0] RX_DATA  = 2'b10;
	localparam [1:0] RX_STOP  = 2'b11;

	localparam [1:0] S_RX  = 2'b00;
	localparam [1:0] S_CHK = 2'b01;
	localparam [1:0] S_WR  = 2'b10;
	localparam [1:0] S_TX  = 2'b11;

	reg  [7:0]  rxb [0:BUF_DEPTH-1];
	reg  [15:0] div_cnt;
	reg  [15:0] cur_div;
	reg         tick;
	reg  [1:0]  rx_st;
	reg  [3:0]  rx_ph;
	reg  [2:0]  rx_bit;
	reg  [7:0]  rx_sh;
	reg         rx_byte_v;
	reg         rx_ferr;
	reg  [9:0]  idle_cnt;
	reg         eof;
	reg  [1:0]  state;
	reg  [5:0]  rx_len;
	reg         rx_full;
	reg         rx_bad;
	reg  [15:0] crc_rx;
	reg  [7:0]  exc;
	reg  [7:0]  exc_q;
	reg  [4:0]  n_q;
	reg  [4:0]  wr_k;
	reg  [4:0]  k;
	reg  [3:0]  ca;
	reg  [15:0] cv;
	reg  [5:0]  vi;
	reg  [5:0]  wi;
	reg  [3:0]  wa;
	reg  [15:0] wv;
	reg  [15:0] crc_tx;
	reg  [5:0]  tx_idx;
	reg  [5:0]  tx_len;
	reg  [7:0]  tx_byte;
	reg  [5:0]  off;
	reg  [3:0]  rd_a;
	reg  [15:0] rd_val;
	reg         tx_busy;
	reg  [8:0]  tx_sh;
	reg  [3:0]  tx_ph;
	reg  [3:0]  tx_bits;

	wire [7:0]  fc     = rxb[`MBS_POS_FC];
	wire [15:0] r_addr = {rxb[2], rxb[3]};
	wire [15:0] qty    = {rxb[4], rxb[5]};
	wire [7:0]  bcnt   = rxb[6];
	wire        is_rd  = (fc == `MBS_FC_RD_HOLD) || (fc == `MBS_FC_RD_INPUT);
	wire        is_wr1 = (fc == `MBS_FC_WR_ONE);
	wire        is_wrm = (fc == `MBS_FC_WR_MANY);
	wire [15:0] n      = is_wr1 ? 16'h0001 : qty;
	wire [16:0] r_last = {1'b0, r_addr} + {1'b0, n} - 17'h00001;
	wire        bcast  = (rxb[`MBS_POS_SLV] == `MBS_BROADCAST);

	function [15:0] crc_upd;
		input [15:0] c;
		input [7:0]  d;
		integer      i;
		reg   [15:0] x;
		begin
			x = c ^ {8'h00, d};
			for (i = 0; i < 8; i = i + 1)
				x = x[0] ? ((x >> 1) ^ `MBS_CRC_POLY) : (x >> 1);
			crc_upd = x;
		end
	endfunction

	// Write legality for one register and value
	// Live state comes in as arguments so the caller's sensitivity sees it
	function [7:0] wr_check;
		input [3:0]  a;
		input [15:0] v;
		input [15:0] unl;
		input        mot;
		input [15:0] lo;
		input [15:0] hi;
		begin
			wr_check = `MBS_EX_NONE;
			if (a < `MBS_A_UNLOCK || a > `MBS_A_RAMP_DOWN)
				wr_check = `MBS_EX_LOCK;
			// lock blocks all but unlock register
			else if (a != `MBS_A_UNLOCK && unl == `MBS_UNLOCK_RST)
				wr_check = `MBS_EX_LOCK;
			else if ((a == `MBS_A_RAMP_UP || a == `MBS_A_RAMP_DOWN) && mot)
				wr_check = `MBS_EX_LOCK;
			// unlock holds 0 or 1 only
			else if (a == `MBS_A_UNLOCK && v > `MBS_UNLOCK_MAX)
				wr_check = `MBS_EX_VALUE;
			else if (a == `MBS_A_SETPOINT && (v < lo || v > hi))
				wr_check = `MBS_EX_VALUE;
		end
	endfunction

	always @*
	begin
		case (baud_code_o)
			3'h0: cur_div = D1200[15:0];
			3'h1: cur_div = D2400[15:0];
			3'h2: cur_div = D4800[15:0];
			3'h4: cur_div = D19200[15:0];
			default: cur_div = D9600[15:0];
		endcase
	end

	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			div_cnt     <= 16'h0000;
			tick        <= 1'b0;
			baud_code_o <= `MBS_BAUD_RST;
		end
		else
		begin
			if (baud_load_i && baud_sel_i <= `MBS_BAUD_MAXC)
				baud_code_o <= baud_sel_i;
			tick <= (div_cnt == 16'h0000);
			if (div_cnt == 16'h0000)
				div_cnt <= cur_div - 16'h0001;
			else
				div_cnt <= div_cnt - 16'h0001;
		end
	end

	// Receiver held idle while driving; the transceiver echo is not ours to parse
	always @(posedge clk_i)
	begin
		if (!rst_n_i || tx_en_o)
		begin
			rx_st     <= RX_IDLE;
			rx_ph     <= 4'h0;
			rx_bit    <= 3'h0;
			rx_sh     <= 8'h00;
			rx_byte_v <= 1'b0;
			rx_ferr   <= 1'b0;
			idle_cnt  <= 10'h000;
			eof       <= 1'b0;
		end
		else
		begin
			rx_byte_v <= 1'b0;
			rx_ferr   <= 1'b0;
			eof       <= 1'b0;
			if (tick)
			begin
				if (rx_st != RX_IDLE || !rx_i)
					idle_cnt <= 10'h000;
				else if (idle_cnt != `MBS_T35_TICKS)
					idle_cnt <= idle_cnt + 10'h001;
				eof <= (idle_cnt == `MBS_T35_TICKS - 10'h001);
				case (rx_st)
					RX_IDLE:
						if (!rx_i)
						begin
							rx_st <= RX_START;
							rx_ph <= 4'h0;
						end
					RX_START:
						if (rx_ph == `MBS_OVS_MID)
						begin
							rx_st  <= rx_i ? RX_IDLE : RX_DATA;
							rx_ph  <= 4'h0;
							rx_bit <= 3'h0;
						end
						else
							rx_ph <= rx_ph + 4'h1;
					RX_DATA:
						if (rx_ph == `MBS_OVS_LAST)
						begin
							rx_sh  <= {rx_i, rx_sh[7:1]};
							rx_ph  <= 4'h0;
							rx_bit <= rx_bit + 3'h1;
							if (rx_bit == 3'h7)
								rx_st <= RX_STOP;
						end
						else
							rx_ph <= rx_ph + 4'h1;
					RX_STOP:
						if (rx_ph == `MBS_OVS_LAST)
						begin
							rx_st     <= RX_IDLE;
							rx_byte_v <= rx_i;
							rx_ferr   <= !rx_i;
						end
						else
							rx_ph <= rx_ph + 4'h1;
					default:
						rx_st <= RX_IDLE;
				endcase
			end
		end
	end

	// exception priority: function, busy, framing/value, address, per register
	always @*
	begin
		exc = `MBS_EX_NONE;
		k   = 5'h00;
		ca  = 4'h0;
		cv  = 16'h0000;
		vi  = 6'h00;
		if (!is_rd && !is_wr1 && !is_wrm)
			exc = `MBS_EX_FUNC;
		else if (busy_i)
			exc = `MBS_EX_BUSY;
		else if (!is_wrm && rx_len != `MBS_LEN_FIX)
			exc = `MBS_EX_VALUE;
		else if (is_wrm && ({3'b000, rx_len} != {1'b0, bcnt} + `MBS_LEN_HDR))
			exc = `MBS_EX_VALUE;
		else if (!is_wr1 && (qty == 16'h0000 || qty > `MBS_MAX_QTY))
			exc = `MBS_EX_VALUE;
		else if (is_wrm && {qty[14:0], 1'b0} != {8'h00, bcnt})
			exc = `MBS_EX_VALUE;
		else if (r_last > {1'b0, `MBS_A_LAST})
			exc = `MBS_EX_ADDR;
		else if (!is_rd)
		begin
			for (k = 5'h00; {11'h000, k} < `MBS_MAX_QTY; k = k + 5'h01)
			begin
				if (exc == `MBS_EX_NONE && {11'h000, k} < n)
				begin
					vi  = is_wr1 ? `MBS_POS_VAL : (`MBS_POS_DATA + {k, 1'b0});
					ca  = r_addr[3:0] + k[3:0];
					cv  = {rxb[vi], rxb[vi + 6'h01]};
					exc = wr_check(ca, cv, param_unlock_o, motor_running_i,
						start_freq_i, max_freq_i);
				end
			end
		end
	end

	always @*
	begin
		wi = is_wr1 ? `MBS_POS_VAL : (`MBS_POS_DATA + {wr_k, 1'b0});
		wa = r_addr[3:0] + wr_k[3:0];
		wv = {rxb[wi], rxb[wi + 6'h01]};
	end

	// Register read mux
	always @*
	begin
		off  = tx_idx - `MBS_LEN_RDH;
		rd_a = r_addr[3:0] + off[4:1];
		case (rd_a)
			`MBS_A_MODEL:     rd_val = MODEL;
			// smallest rating reads as all ones
			`MBS_A_RATING:    rd_val = (rating_sel_i == 2'b00) ? `MBS_RATING_SMALL :
				{14'h0000, rating_sel_i - 2'b01};
			`MBS_A_SUPPLY:    rd_val = {15'h0000, supply_high_i};
			`MBS_A_FIRMWARE:  rd_val = FW_VER;
			`MBS_A_UNLOCK:    rd_val = param_unlock_o;
			`MBS_A_SETPOINT:  rd_val = speed_setpoint_o;
			`MBS_A_RUN:       rd_val = {11'h000, run_command_o};
			`MBS_A_RAMP_UP:   rd_val = ramp_up_time_o;
			`MBS_A_RAMP_DOWN: rd_val = ramp_down_time_o;
			`MBS_A_CURRENT:   rd_val = current_i;
			`MBS_A_FREQ:      rd_val = freq_i;
			`MBS_A_VOLT:      rd_val = volt_i;
			`MBS_A_BUS_VOLT:  rd_val = bus_volt_i;
			`MBS_A_POWER:     rd_val = power_i;
			`MBS_A_STATE:     rd_val = {1'b0, remote_setpoint_source_i, remote_runstop_source_i,
				2'b00, brake_open_i & brake_output_function_select_i, 1'b0, drive_state_i};
			default:          rd_val = {4'h0, fault_cause_i};
		endcase
	end

	// reply byte stream, CRC low byte first
	always @*
	begin
		if (tx_idx == tx_len)
			tx_byte = crc_tx[7:0];
		else if (tx_idx == tx_len + 6'h01)
			tx_byte = crc_tx[15:8];
		else if (tx_idx == `MBS_POS_SLV)
			tx_byte = rxb[`MBS_POS_SLV];
		else if (exc_q != `MBS_EX_NONE)
			tx_byte = (tx_idx == `MBS_POS_FC) ? (fc | `MBS_FC_EXC) : exc_q;
		else if (is_rd && tx_idx == `MBS_POS_FC)
			tx_byte = fc;
		else if (is_rd && tx_idx == `MBS_POS_CNT)
			tx_byte = {2'b00, n_q, 1'b0};
		else if (is_rd)
			tx_byte = off[0] ? rd_val[7:0] : rd_val[15:8];
		else
			tx_byte = rxb[tx_idx];
	end

	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			state            <= S_RX;
			rx_len           <= 6'h00;
			rx_full          <= 1'b0;
			rx_bad           <= 1'b0;
			crc_rx           <= `MBS_CRC_INIT;
			exc_q            <= `MBS_EX_NONE;
			n_q              <= 5'h00;
			wr_k             <= 5'h00;
			crc_tx           <= `MBS_CRC_INIT;
			tx_idx           <= 6'h00;
			tx_len           <= 6'h00;
			tx_busy          <= 1'b0;
			tx_sh            <= 9'h1ff;
			tx_ph            <= 4'h0;
			tx_bits          <= 4'h0;
			tx_o             <= 1'b1;
			tx_en_o          <= 1'b0;
			param_unlock_o   <= `MBS_UNLOCK_RST;
			speed_setpoint_o <= 16'h0000;
			run_command_o    <= 5'h00;
			ramp_up_time_o   <= RAMP_UP_RST;
			ramp_down_time_o <= RAMP_DN_RST;
			fault_reset_o    <= 1'b0;
		end
		else
		begin
			fault_reset_o <= 1'b0;
			case (state)
				// idle until a request frame arrives
				S_RX:
				begin
					if (rx_byte_v)
					begin
						if (!rx_full)
						begin
							rxb[rx_len] <= rx_sh;
							crc_rx      <= crc_upd(crc_rx, rx_sh);
							rx_full     <= (rx_len == BUF_LAST);
							rx_len      <= rx_len + 6'h01;
						end
						else
							rx_bad <= 1'b1;
					end
					if (rx_ferr)
						rx_bad <= 1'b1;
					if (eof && rx_len != 6'h00)
					begin
						// Bad CRC, short frame or other address: dropped silently
						if (!rx_bad && crc_rx == 16'h0000 && rx_len >= `MBS_LEN_MIN &&
							(rxb[`MBS_POS_SLV] == slave_addr_i || bcast))
							state <= S_CHK;
						else
						begin
							rx_len  <= 6'h00;
							rx_full <= 1'b0;
							rx_bad  <= 1'b0;
							crc_rx  <= `MBS_CRC_INIT;
						end
					end
				end
				// decide the answer once, with stable inputs
				S_CHK:
				begin
					exc_q  <= exc;
					n_q    <= n[4:0];
					wr_k   <= 5'h00;
					crc_tx <= `MBS_CRC_INIT;
					tx_idx <= 6'h00;
					if (exc != `MBS_EX_NONE)
						tx_len <= `MBS_LEN_EXC;
					else if (is_rd)
						tx_len <= `MBS_LEN_RDH + {n[4:0], 1'b0};
					else
						tx_len <= `MBS_LEN_ECHO;
					if (exc == `MBS_EX_NONE && !is_rd)
						state <= S_WR;
					else if (bcast)
						state <= S_RX;
					else
					begin
						state   <= S_TX;
						tx_en_o <= 1'b1;
					end
				end
				S_WR:
				begin
					case (wa)
						`MBS_A_UNLOCK:    param_unlock_o <= wv;
						`MBS_A_SETPOINT:  speed_setpoint_o <= wv;
						`MBS_A_RAMP_UP:   ramp_up_time_o <= wv;
						`MBS_A_RAMP_DOWN: ramp_down_time_o <= wv;
						`MBS_A_RUN:
						begin
							// command bits 0..4 kept, bit 5 up dropped
							run_command_o <= wv[`MBS_RC_W-1:0];
							fault_reset_o <= wv[`MBS_RC_FRST] & ~run_command_o[`MBS_RC_FRST];
						end
						default:
							wr_k <= wr_k;
					endcase
					wr_k <= wr_k + 5'h01;
					if (wr_k == n_q - 5'h01)
					begin
						state   <= bcast ? S_RX : S_TX;
						tx_en_o <= !bcast;
					end
				end
				S_TX:
				begin
					if (!tx_busy)
					begin
						if (tx_idx == tx_len + 6'h02)
						begin
							state   <= S_RX;
							tx_en_o <= 1'b0;
						end
						else
						begin
							tx_busy <= 1'b1;
							tx_o    <= 1'b0;
							tx_sh   <= {1'b1, tx_byte};
							tx_ph   <= 4'h0;
							tx_bits <= 4'h0;
							tx_idx  <= tx_idx + 6'h01;
							if (tx_idx < tx_len)
								crc_tx <= crc_upd(crc_tx, tx_byte);
						end
					end
					else if (tick)
					begin
						tx_ph <= tx_ph + 4'h1;
						if (tx_ph == `MBS_OVS_LAST)
						begin
							if (tx_bits == `MBS_TX_BITS_LAST)
								tx_busy <= 1'b0;
							else
							begin
								tx_o    <= tx_sh[0];
								tx_sh   <= {1'b1, tx_sh[8:1]};
								tx_bits <= tx_bits + 4'h1;
							end
						end
					end
				end
				default:
					state <= S_RX;
			endcase
			if (state != S_RX && state != S_CHK && !tx_en_o && !(state == S_WR))
				state <= S_RX;
			if ((state == S_CHK && bcast && (exc != `MBS_EX_NONE || is_rd)) ||
				(state == S_WR && bcast && wr_k == n_q - 5'h01) ||
				(state == S_TX && !tx_busy && tx_idx == tx_len + 6'h02))
			begin
				rx_len  <= 6'h00;
				rx_full <= 1'b0;
				rx_bad  <= 1'b0;
				crc_rx  <= `MBS_CRC_INIT;
			end
		end
	end

endmodule

//--- verif/mbs_drive_slave_assertions.sv
// Checker for the drive slave core: reset state, line idle, baud, lock, pulse.
// Sees only the core's top-level ports; bound to every instance below.
`timescale 1ns/1ps
module mbs_drive_slave_chk (
	input wire        clk_i,
	input wire        rst_n_i,
	input wire [2:0]  baud_sel_i,
	input wire        baud_load_i,
	input wire        tx_o,
	input wire        tx_en_o,
	input wire [15:0] start_freq_i,
	input wire [15:0] max_freq_i,
	input wire [15:0] param_unlock_o,
	input wire [15:0] speed_setpoint_o,
	input wire [4:0]  run_command_o,
	input wire        fault_reset_o,
	input wire [2:0]  baud_code_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_start_bit;
		!tx_o [*8];
	endsequence
	sequence s_pulse_end;
		!fault_reset_o;
	endsequence

	// Reset itself is the cause here, so no disable
	property p_reset_state;
		disable iff (1'b0)
		!rst_n_i |=> tx_o && !tx_en_o && baud_code_o == 3'h3 && param_unlock_o == 16'h0000;
	endproperty
	property p_idle_high;
		!tx_en_o |-> tx_o;
	endproperty
	property p_start_bit;
		$rose(tx_en_o) |=> s_start_bit;
	endproperty
	property p_pulse_once;
		fault_reset_o |=> s_pulse_end;
	endproperty
	property p_pulse_cause;
		fault_reset_o |-> run_command_o[3] && !$past(run_command_o[3]);
	endproperty
	property p_baud_load;
		baud_load_i && baud_sel_i <= 3'h4 |=> baud_code_o == $past(baud_sel_i);
	endproperty
	property p_baud_keep;
		baud_load_i && baud_sel_i > 3'h4 |=> $stable(baud_code_o);
	endproperty
	property p_unlock_range;
		param_unlock_o <= 16'h0001;
	endproperty
	property p_setpoint_window;
		$changed(speed_setpoint_o) |-> speed_setpoint_o >= start_freq_i
			&& speed_setpoint_o <= max_freq_i;
	endproperty
	// Unlock may be cleared one cycle earlier in the same frame
	property p_setpoint_lock;
		$changed(speed_setpoint_o) |-> $past(param_unlock_o, 2) == 16'h0001;
	endproperty

	a_reset_state: assert property (p_reset_state)
		else $error("reset state wrong");
	a_idle_high: assert property (p_idle_high)
		else $error("line not idle high");
	a_start_bit: assert property (p_start_bit)
		else $error("no start bit after enable");
	a_pulse_once: assert property (p_pulse_once)
		else $error("fault reset pulse too long");
	a_pulse_cause: assert property (p_pulse_cause)
		else $error("fault reset without rising bit");
	a_baud_load: assert property (p_baud_load)
		else $error("baud code not loaded");
	a_baud_keep: assert property (p_baud_keep)
		else $error("bad baud code accepted");
	a_unlock_range: assert property (p_unlock_range)
		else $error("unlock value out of range");
	a_setpoint_window: assert property (p_setpoint_window)
		else $error("setpoint outside window");
	a_setpoint_lock: assert property (p_setpoint_lock)
		else $error("setpoint written while locked");
endmodule

bind mbs_drive_slave mbs_drive_slave_chk chk_u (.*);

//--- verif/mbs_master_model.sv
// Master host model: sends RTU requests with CRC and captures the reply.
// Assumes 8N1 framing, bit time of BIT_CLKS clocks, biased line idle high.
`timescale 1ns/1ps
module mbs_master_model #(
	parameter BIT_CLKS = 32
) (
	input  wire clk_i,
	input  wire tx_i,
	input  wire tx_en_i,
	output reg  line_o
);
	logic [7:0] rsp [$];

	initial line_o = 1'b1;

	function automatic logic [15:0] crc16(input logic [7:0] q [$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i])
		begin
			c = c ^ {8'h00, q[i]};
			repeat (8)
				c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction

	task automatic put_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int k = 0; k < 10; k++)
		begin
			@(posedge clk_i);
			line_o <= f[k];
			repeat (BIT_CLKS - 1)
				@(posedge clk_i);
		end
	endtask

	task automatic send(input logic [7:0] q [$]);
		logic [15:0] c;
		c = crc16(q);
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		foreach (q[i])
			put_byte(q[i]);
	endtask

	// Samples mid-bit so edge races cannot shift a bit
	task automatic recv;
		int n;
		logic [7:0] b;
		rsp.delete();
		n = 0;
		while (!tx_en_i && n < 4000)
		begin
			@(posedge clk_i);
			n++;
		end
		while (tx_en_i)
		begin
			@(posedge clk_i);
			if (!tx_i)
			begin
				repeat (BIT_CLKS / 2) @(posedge clk_i);
				for (int k = 0; k < 8; k++)
				begin
					repeat (BIT_CLKS) @(posedge clk_i);
					b[k] = tx_i;
				end
				repeat (BIT_CLKS) @(posedge clk_i);
				rsp.push_back(b);
			end
		end
		// quiet gap before the next poll
		repeat (BIT_CLKS * 40) @(posedge clk_i);
	endtask
endmodule

//--- verif/mbs_drive_slave_test.sv
// Self-checking bench for the drive slave core against a master host model.
// CLK_HZ is lowered so one tick at 19200 is two clocks; keeps the run short.
`timescale 1ns/1ps
module mbs_drive_slave_test;
	localparam [7:0] SLV = 8'h11;
	reg         clk_i = 1'b0;
	reg         rst_n_i = 1'b0;
	reg  [7:0]  slave_addr_i = SLV;
	reg  [2:0]  baud_sel_i = 3'h0;
	reg         baud_load_i = 1'b0;
	wire        rx_i;
	wire        tx_o;
	wire        tx_en_o;
	reg  [1:0]  rating_sel_i;
	reg         supply_high_i;
	reg  [15:0] start_freq_i = 16'h0032;
	reg  [15:0] max_freq_i = 16'h1770;
	reg         motor_running_i;
	reg         busy_i;
	reg  [15:0] current_i;
	reg  [15:0] freq_i;
	reg  [15:0] volt_i;
	reg  [15:0] bus_volt_i;
	reg  [15:0] power_i;
	reg  [8:0]  drive_state_i;
	reg         brake_open_i;
	reg         brake_output_function_select_i;
	reg         remote_runstop_source_i;
	reg         remote_setpoint_source_i;
	reg  [11:0] fault_cause_i;
	wire [15:0] param_unlock_o;
	wire [15:0] speed_setpoint_o;
	wire [4:0]  run_command_o;
	wire [15:0] ramp_up_time_o;
	wire [15:0] ramp_down_time_o;
	wire        fault_reset_o;
	wire [2:0]  baud_code_o;
	int         error_cnt = 0;
	int         check_count = 0;
	int         cycles = 0;
	int         pulses = 0;

	// Identity value arbitrary
	mbs_drive_slave #(.CLK_HZ(614400), .MODEL(16'h005a), .FW_VER(16'h0203)) dut_u (.*);
	mbs_master_model #(.BIT_CLKS(32)) m_u (.clk_i(clk_i), .tx_i(tx_o), .tx_en_i(tx_en_o),
		.line_o(rx_i));

	always #4 clk_i = ~clk_i;

	always @(posedge clk_i)
	begin
		pulses <= pulses + (fault_reset_o === 1'b1);
		cycles <= cycles + 1;
		if (cycles == 100000)
		begin
			error_cnt++;
			print_verdict;
		end
	end

	task automatic print_verdict;
		if (error_cnt == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic xact(input logic [7:0] req [$], input logic [7:0] exp [$]);
		m_u.send(req);
		m_u.recv();
		chk("reply length", m_u.rsp.size(), exp.size() + 2);
		chk("reply crc", m_u.crc16(m_u.rsp), 16'h0000);
		foreach (exp[i])
			chk("reply byte", (i < m_u.rsp.size()) ? m_u.rsp[i] : 8'hxx, exp[i]);
	endtask

	task automatic load_baud(input logic [2:0] c);
		@(posedge clk_i);
		baud_sel_i <= c;
		baud_load_i <= 1'b1;
		@(posedge clk_i);
		baud_load_i <= 1'b0;
		@(negedge clk_i);
	endtask

	task automatic s_reset_baud;
		@(negedge clk_i);
		chk("baud code", baud_code_o, 3'h3);
		chk("ramp up", ramp_up_time_o, 16'h0032);
		chk("ramp down", ramp_down_time_o, 16'h0064);
		repeat (200) @(negedge clk_i);
		chk("tx enable idle", tx_en_o, 1'b0);
		load_baud(3'h5);
		chk("baud ignored", baud_code_o, 3'h3);
		load_baud(3'h4);
		chk("baud fast", baud_code_o, 3'h4);
	endtask

	task automatic s_identity;
		@(posedge clk_i);
		rating_sel_i <= 2'h0;
		supply_high_i <= 1'b1;
		xact('{SLV, 8'h03, 8'h00, 8'h00, 8'h00, 8'h04},
			'{SLV, 8'h03, 8'h08, 8'h00, 8'h5a, 8'hff, 8'hff, 8'h00, 8'h01, 8'h02, 8'h03});
	endtask

	task automatic s_monitor;
		@(posedge clk_i);
		{current_i, freq_i, volt_i} <= {16'h1234, 16'h0bb8, 16'h0dc0};
		{bus_volt_i, power_i, drive_state_i} <= {16'h0c80, 16'h0007, 9'h155};
		{brake_open_i, brake_output_function_select_i} <= 2'h3;
		{remote_runstop_source_i, remote_setpoint_source_i} <= 2'h3;
		fault_cause_i <= 12'ha5c;
		xact('{SLV, 8'h04, 8'h00, 8'h09, 8'h00, 8'h07},
			'{SLV, 8'h04, 8'h0e, 8'h12, 8'h34, 8'h0b, 8'hb8, 8'h0d, 8'hc0, 8'h0c, 8'h80,
			8'h00, 8'h07, 8'h65, 8'h55, 8'h0a, 8'h5c});
	endtask

	task automatic s_lock_unlock;
		xact('{SLV, 8'h06, 8'h00, 8'h05, 8'h0b, 8'hb8}, '{SLV, 8'h86, 8'h14});
		chk("setpoint kept", speed_setpoint_o, 16'h0000);
		xact('{SLV, 8'h06, 8'h00, 8'h04, 8'h00, 8'h01},
			'{SLV, 8'h06, 8'h00, 8'h04, 8'h00, 8'h01});
		chk("unlock", param_unlock_o, 16'h0001);
	endtask

	task automatic s_commands;
		int p0;
		p0 = pulses;
		xact('{SLV, 8'h10, 8'h00, 8'h05, 8'h00, 8'h02, 8'h04, 8'h0b, 8'hb8, 8'h00, 8'h0a},
			'{SLV, 8'h10, 8'h00, 8'h05, 8'h00, 8'h02});
		chk("setpoint", speed_setpoint_o, 16'h0bb8);
		chk("run", run_command_o, 5'h0a);
		chk("reset pulses", pulses - p0, 1);
		xact('{SLV, 8'h06, 8'h00, 8'h06, 8'h00, 8'h1a},
			'{SLV, 8'h06, 8'h00, 8'h06, 8'h00, 8'h1a});
		chk("run estop", run_command_o, 5'h1a);
		chk("no new pulse", pulses - p0, 1);
	endtask

	task automatic s_exceptions;
		logic [55:0] e;
		logic [55:0] tbl [6];
		tbl = '{56'h05_00_00_01_01_00_00, 56'h03_0f_00_02_02_00_00, 56'h06_05_17_71_03_00_00,
			56'h06_00_00_01_14_00_00, 56'h06_07_00_05_14_01_00, 56'h03_00_00_01_06_00_01};
		foreach (tbl[i])
		begin
			e = tbl[i];
			@(posedge clk_i);
			motor_running_i <= e[8];
			busy_i <= e[0];
			xact('{SLV, e[55:48], 8'h00, e[47:40], e[39:32], e[31:24]},
				'{SLV, e[55:48] | 8'h80, e[23:16]});
		end
		chk("ramp kept", ramp_up_time_o, 16'h0032);
		chk("setpoint kept", speed_setpoint_o, 16'h0bb8);
	endtask

	initial
	begin
		{rating_sel_i, supply_high_i, motor_running_i, busy_i} = '0;
		{current_i, freq_i, volt_i, bus_volt_i, power_i} = '0;
		{drive_state_i, brake_open_i, brake_output_function_select_i} = '0;
		{remote_runstop_source_i, remote_setpoint_source_i, fault_cause_i} = '0;
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		s_reset_baud;
		s_identity;
		s_monitor;
		s_lock_unlock;
		s_commands;
		s_exceptions;
		print_verdict;
	end
endmodule
